/* frcu_regs.svh */
/*
  Register indices, field positions and reset values of the free-running counter unit.
  Assumes it is included by its bare name, after the package, by each design file that needs it.
*/
//
// Functional notes
// - Eight word slots, two registers; reserved slots and unused bits read zero, writes ignored.
// - Overflow flag sets when the counter rolls from all ones to zero.
// - A set overflow flag with nonzero level raises an interrupt request at that level.
// - Only hardware sets the flag; software clears by reading one then writing zero.
// - An overflow between the flag read and the clearing write cancels the clear.
// - Three-bit level field, read/write anytime, reset zero; zero disables, seven highest.
// - Arbitration bit joins the three-bit field outside to form a unique identifier.
// - Drive bits connect the count to bus A, bus B, both or neither.
// - Bit 7 reads the synchronised pin level; writes ignored, reset clears it to zero until the synchroniser samples the pin.
// - Source codes 0 to 5 pick prescaled ticks, 6 falling pin edge, 7 rising.
// - Counter register at index two is read/write, reads live count, resets to zero.
// - Control fields: flag 15, level 14:12, arbitration 11, drives 9 and 8, pin 7, source 2:0.
// - Counter writes load directly; writing zero at all ones sets no flag.
// - Halt holds the count, registers stay accessible, pin bit keeps tracking.
// - No counting after reset until the shared prescaler runs.
// - Pin is synchronised before edge detection; source changes pass no spurious edge.
`ifndef FRCU_REGS_SVH
`define FRCU_REGS_SVH

// Register indices; the byte address is four times the index.
// Odd indices are unused word slots and behave like the reserved ones.
`define FRCU_IDX_SC        3'h0
`define FRCU_IDX_CNT       3'h2
`define FRCU_IDX_RSV0      3'h4
`define FRCU_IDX_RSV1      3'h6

// Control register field positions.
`define FRCU_SC_OVF_BIT    15
`define FRCU_SC_IL_HI      14
`define FRCU_SC_IL_LO      12
`define FRCU_SC_ARB_BIT    11
`define FRCU_SC_DRIVE_BUS_A_BIT   9
`define FRCU_SC_DRIVE_BUS_B_BIT   8
`define FRCU_SC_PIN_BIT    7
`define FRCU_SC_SRC_HI     2
`define FRCU_SC_SRC_LO     0

// Source codes for the pin edges.
`define FRCU_SRC_PIN_FALL  3'h6
`define FRCU_SRC_PIN_RISE  3'h7

// Reset values and the counter maximum.
`define FRCU_CNT_RST       16'h0000
`define FRCU_CNT_MAX       16'hffff
`define FRCU_IL_RST        3'h0
`define FRCU_SRC_RST       3'h0

`endif

/* frcu_pkg.sv */
/*
  Types shared by the free-running counter unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package frcu_pkg;

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic        rise;
    logic        fall;
  } frcu_edge_state_t;

  typedef struct packed {
    logic        ovf;
    logic [2:0]  il;
    logic        arb;
    logic        drv_a;
    logic        drv_b;
    logic [2:0]  src;
    logic [15:0] count;
    logic        clr_armed;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq_req;
    logic [2:0]  irq_level;
    logic [3:0]  arb_id;
    logic [15:0] tbb_a;
    logic        tbb_a_en;
    logic [15:0] tbb_b;
    logic        tbb_b_en;
  } frcu_state_t;

endpackage

/* frcu_edge_if.sv */
/*
  Carries the synchronised pin level and its edges from the detector to the counter.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface frcu_edge_if;
  logic pin_level;
  logic rise;
  logic fall;
  logic rearm;

  modport detector (output pin_level, output rise, output fall, input rearm);
  modport user (input pin_level, input rise, input fall, output rearm);
endinterface

/* frcu_pin_edge.sv */
/*
  Two-flop synchroniser and edge detector for the count input pin.
  Assumes the pin is asynchronous and toggles no faster than a quarter of pclk.
*/
`timescale 1ns/1ps
module frcu_pin_edge
  import frcu_pkg::*;
(
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw pin.
  input  wire logic pin_raw,
  // Toward the counter.
  frcu_edge_if.detector ep
);

  frcu_edge_state_t s_r;
  frcu_edge_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // The first flop feeds only the second; edges compare the second with its delayed copy.
  always_comb begin
    s_nxt       = s_r;
    s_nxt.sync1 = pin_raw;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = s_r.sync2;
    // A source change drops any edge in flight so it cannot count.
    if (ep.rearm) begin
      s_nxt.rise = 1'b0;
      s_nxt.fall = 1'b0;
    end else begin
      s_nxt.rise = s_r.sync2 & ~s_r.prev;
      s_nxt.fall = ~s_r.sync2 & s_r.prev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ep.pin_level = s_r.sync2;
  assign ep.rise      = s_r.rise;
  assign ep.fall      = s_r.fall;

endmodule

/* frcu_top.sv */
/*
  Free-running 16-bit counter unit with APB register access, time base bus drive
  and a levelled interrupt request.
  Assumes prescaled ticks and the run and halt controls come from logic on pclk,
  and that the count pin is asynchronous.
*/
`timescale 1ns/1ps
`include "frcu_regs.svh"
module frcu_top
  import frcu_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Shared prescaler and module controls.
  input  wire logic [5:0]        prescaled_tick,
  input  wire logic              prescaler_run,
  input  wire logic              halt_req,
  input  wire logic [2:0]        arb_id_field,
  // Count pin.
  input  wire logic              count_input_pin,
  // Time base buses.
  output logic [15:0]            tbb_a_data,
  output logic                   tbb_a_en,
  output logic [15:0]            tbb_b_data,
  output logic                   tbb_b_en,
  // Interrupt request toward the intermodule bus.
  output logic                   irq_req,
  output logic [2:0]             irq_level,
  output logic [3:0]             irq_arb_id
);

  if (ADDR_W < 6) begin : g_addr_chk
    $error("ADDR_W must be at least 6");
  end

  frcu_state_t s_r;
  frcu_state_t s_nxt;
  frcu_edge_if eif ();

  logic        inc;
  logic        access;
  logic        done;
  logic        mapped;
  logic        sc_wr;
  logic        cnt_wr;
  logic        rearm;
  logic [2:0]  idx;
  logic [15:0] wd;

  ////////////////////////////////////////////////////////////////////////////////
  frcu_pin_edge frcu_pin_edge_i (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_raw (count_input_pin),
    .ep      (eif.detector)
  );

  // Read view of one register slot; reserved slots and unused bits read zero.
  function automatic logic [15:0] rd_word(input frcu_state_t st, input logic [2:0] i,
                                          input logic pin);
    logic [15:0] w;
    w = 16'h0000;
    case (i)
      `FRCU_IDX_SC: begin
        w[`FRCU_SC_OVF_BIT]                  = st.ovf;
        w[`FRCU_SC_IL_HI:`FRCU_SC_IL_LO]     = st.il;
        w[`FRCU_SC_ARB_BIT]                  = st.arb;
        w[`FRCU_SC_DRIVE_BUS_A_BIT]                 = st.drv_a;
        w[`FRCU_SC_DRIVE_BUS_B_BIT]                 = st.drv_b;
        w[`FRCU_SC_PIN_BIT]                  = pin;
        w[`FRCU_SC_SRC_HI:`FRCU_SC_SRC_LO]   = st.src;
      end
      `FRCU_IDX_CNT: w = st.count;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  assign idx    = paddr[4:2];
  assign mapped = (paddr[ADDR_W-1:5] == '0);
  assign access = psel && penable;
  assign done   = access && s_r.pready;
  assign sc_wr  = done && pwrite && mapped && (idx == `FRCU_IDX_SC);
  assign cnt_wr = done && pwrite && mapped && (idx == `FRCU_IDX_CNT);

  // Byte lanes merge into the current register image.
  always_comb begin
    wd = rd_word(s_r, idx, eif.pin_level);
    if (pstrb[0]) begin
      wd[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      wd[15:8] = pwdata[15:8];
    end
  end

  assign rearm     = sc_wr && pstrb[0] && (wd[`FRCU_SC_SRC_HI:`FRCU_SC_SRC_LO] != s_r.src);
  assign eif.rearm = rearm;

  // Count qualifier: the run control gates everything, halt freezes the count.
  always_comb begin
    if (!prescaler_run || halt_req) begin
      inc = 1'b0;
    end else if (s_r.src == `FRCU_SRC_PIN_FALL) begin
      inc = eif.fall;
    end else if (s_r.src == `FRCU_SRC_PIN_RISE) begin
      inc = eif.rise;
    end else begin
      inc = prescaled_tick[s_r.src];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt         = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    // The answer comes one cycle into the access phase so read data is registered.
    if (access && !s_r.pready) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !mapped;
      s_nxt.prdata  = mapped ? {16'h0000, rd_word(s_r, idx, eif.pin_level)} : 32'h0000_0000;
    end
    // Arm from the image that the read returned, so a flag that rose after the data
    // was captured is never cleared by software that has not seen it.
    if (done && !pwrite && mapped && (idx == `FRCU_IDX_SC) &&
        s_r.prdata[`FRCU_SC_OVF_BIT]) begin
      s_nxt.clr_armed = 1'b1;
    end
    if (sc_wr && pstrb[1]) begin
      s_nxt.il    = wd[`FRCU_SC_IL_HI:`FRCU_SC_IL_LO];
      s_nxt.arb   = wd[`FRCU_SC_ARB_BIT];
      s_nxt.drv_a = wd[`FRCU_SC_DRIVE_BUS_A_BIT];
      s_nxt.drv_b = wd[`FRCU_SC_DRIVE_BUS_B_BIT];
      if (!wd[`FRCU_SC_OVF_BIT] && s_r.clr_armed) begin
        s_nxt.ovf       = 1'b0;
        s_nxt.clr_armed = 1'b0;
      end
    end
    if (sc_wr && pstrb[0]) begin
      s_nxt.src = wd[`FRCU_SC_SRC_HI:`FRCU_SC_SRC_LO];
    end
    // A software load beats a count in the same cycle and never flags overflow.
    if (cnt_wr) begin
      s_nxt.count = wd;
    end else if (inc) begin
      s_nxt.count = s_r.count + 16'h0001;
      if (s_r.count == `FRCU_CNT_MAX) begin
        // Placed after the clear so a same-cycle overflow keeps the flag set.
        s_nxt.ovf       = 1'b1;
        s_nxt.clr_armed = 1'b0;
      end
    end
    s_nxt.irq_req   = s_nxt.ovf && (s_nxt.il != 3'h0);
    s_nxt.irq_level = s_nxt.irq_req ? s_nxt.il : 3'h0;
    s_nxt.arb_id    = {s_nxt.arb, arb_id_field};
    s_nxt.tbb_a_en  = s_nxt.drv_a;
    s_nxt.tbb_b_en  = s_nxt.drv_b;
    s_nxt.tbb_a     = s_nxt.drv_a ? s_nxt.count : 16'h0000;
    s_nxt.tbb_b     = s_nxt.drv_b ? s_nxt.count : 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r        <= '0;
      s_r.count  <= `FRCU_CNT_RST;
      s_r.il     <= `FRCU_IL_RST;
      s_r.src    <= `FRCU_SRC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready     = s_r.pready;
  assign prdata     = s_r.prdata;
  assign pslverr    = s_r.pslverr;
  assign tbb_a_data = s_r.tbb_a;
  assign tbb_a_en   = s_r.tbb_a_en;
  assign tbb_b_data = s_r.tbb_b;
  assign tbb_b_en   = s_r.tbb_b_en;
  assign irq_req    = s_r.irq_req;
  assign irq_level  = s_r.irq_level;
  assign irq_arb_id = s_r.arb_id;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_ovf_on_roll:
    assert property (@(posedge pclk) disable iff (!presetn)
      (inc && !cnt_wr && s_r.count == 16'hffff) |=> (s_r.ovf && s_r.count == 16'h0000))
    else $error("overflow flag not set on roll to zero");

  chk_irq_follows:
    assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(s_r.ovf) && s_r.il != 3'h0) |-> (irq_req && irq_level == s_r.il))
    else $error("interrupt not raised at the programmed level");

  chk_irq_drops:
    assert property (@(posedge pclk) disable iff (!presetn)
      (irq_req && sc_wr && pstrb[1] && wd[14:12] == 3'h0) |=> !irq_req)
    else $error("interrupt request did not drop with level zero");

  chk_clear_lost:
    assert property (@(posedge pclk) disable iff (!presetn)
      (inc && !cnt_wr && s_r.count == 16'hffff) |=> (s_r.ovf && !s_r.clr_armed))
    else $error("overflow did not cancel a pending clear");

  chk_clear_needs_read:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ovf && !s_r.clr_armed) |=> s_r.ovf)
    else $error("overflow flag cleared without a prior read");

  chk_load_no_flag:
    assert property (@(posedge pclk) disable iff (!presetn)
      (cnt_wr && wd == 16'h0000 && s_r.count == 16'hffff && !s_r.ovf)
        |=> (!s_r.ovf && s_r.count == 16'h0000 && !irq_req))
    else $error("counter load of zero flagged an overflow");

  chk_halt_holds:
    assert property (@(posedge pclk) disable iff (!presetn)
      (halt_req && !cnt_wr) [*2] |=> $stable(s_r.count))
    else $error("count moved during halt");

  chk_run_gate:
    assert property (@(posedge pclk) disable iff (!presetn)
      (!prescaler_run && !cnt_wr) |=> (s_r.count == $past(s_r.count)))
    else $error("count moved with prescaler stopped");

  chk_step_one:
    assert property (@(posedge pclk) disable iff (!presetn)
      (inc && !cnt_wr) |=> (s_r.count == $past(s_r.count) + 16'h0001))
    else $error("count did not step by one");

  chk_rearm_quiet:
    assert property (@(posedge pclk) disable iff (!presetn)
      rearm |=> (!eif.rise && !eif.fall))
    else $error("edge passed across a source change");

  chk_reserved_zero:
    assert property (@(posedge pclk) disable iff (!presetn)
      (access && !s_r.pready && !pwrite && idx != `FRCU_IDX_SC && idx != `FRCU_IDX_CNT)
        |=> (pready && prdata == 32'h0000_0000))
    else $error("reserved slot read nonzero");

  chk_bus_drive:
    assert property (@(posedge pclk) disable iff (!presetn)
      (sc_wr && pstrb[1]) |=> (tbb_a_en == wd[9] && tbb_b_en == wd[8]))
    else $error("bus drive does not follow the drive bits");

  chk_tbb_a_value:
    assert property (@(posedge pclk) disable iff (!presetn)
      tbb_a_data == (tbb_a_en ? s_r.count : 16'h0000))
    else $error("bus A does not carry the count");

  chk_tbb_b_value:
    assert property (@(posedge pclk) disable iff (!presetn)
      tbb_b_data == (tbb_b_en ? s_r.count : 16'h0000))
    else $error("bus B does not carry the count");

  chk_irq_level:
    assert property (@(posedge pclk) disable iff (!presetn)
      irq_req |-> (irq_level == s_r.il && s_r.il != 3'h0))
    else $error("interrupt level differs from the level field");

  chk_irq_matches:
    assert property (@(posedge pclk) disable iff (!presetn)
      irq_req == (s_r.ovf && s_r.il != 3'h0))
    else $error("interrupt request does not follow flag and level");

  chk_ovf_sticky:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.ovf && !(sc_wr && pstrb[1])) |=> s_r.ovf)
    else $error("overflow flag dropped without a control write");

  chk_ovf_hw_only:
    assert property (@(posedge pclk) disable iff (!presetn)
      (!s_r.ovf && !(inc && !cnt_wr && s_r.count == `FRCU_CNT_MAX)) |=> !s_r.ovf)
    else $error("overflow flag set without a roll to zero");

  chk_unmapped_err:
    assert property (@(posedge pclk) disable iff (!presetn)
      (access && !s_r.pready && !mapped) |=> (pready && pslverr))
    else $error("unmapped access not refused");

  cov_roll_irq:
    cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_req));
  cov_pin_count:
    cover property (@(posedge pclk) disable iff (!presetn) inc && s_r.src[2:1] == 2'b11);
  cov_sw_clear:
    cover property (@(posedge pclk) disable iff (!presetn) $fell(s_r.ovf));
  cov_clear_lost:
    cover property (@(posedge pclk) disable iff (!presetn)
      s_r.clr_armed ##1 (s_r.ovf && !s_r.clr_armed));

endmodule

/* frcu_tbb_model.sv */
/*
  Model of a timer submodule that samples the two time base buses.
  Assumes it runs on the same pclk as the counter unit.
*/
`timescale 1ns/1ps
module frcu_tbb_model (
  // Clock.
  input  wire logic        pclk,
  // Time base buses.
  input  wire logic [15:0] tbb_a_data,
  input  wire logic        tbb_a_en,
  input  wire logic [15:0] tbb_b_data,
  input  wire logic        tbb_b_en,
  // Last value captured from each driven bus.
  output logic      [15:0] seen_a,
  output logic      [15:0] seen_b
);
  // An undriven bus is not captured, so a stale time base stays visibly stale.
  always_ff @(posedge pclk) begin
    if (tbb_a_en) begin
      seen_a <= tbb_a_data;
    end
    if (tbb_b_en) begin
      seen_b <= tbb_b_data;
    end
  end
endmodule

/* frcu_top_bench.sv */
/*
  Self-checking bench for the free-running counter unit.
  Assumes the design files and the bus model are compiled first.
*/
`timescale 1ns/1ps
`include "frcu_regs.svh"
module frcu_top_bench;
  import frcu_pkg::*;
  localparam logic [11:0] A_SC  = {7'h00, `FRCU_IDX_SC, 2'b00};
  localparam logic [11:0] A_CNT = {7'h00, `FRCU_IDX_CNT, 2'b00};
  localparam logic [11:0] A_R2  = {7'h00, `FRCU_IDX_RSV0, 2'b00};
  localparam logic [11:0] A_R3  = {7'h00, `FRCU_IDX_RSV1, 2'b00};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [5:0]  prescaled_tick;
  logic        prescaler_run;
  logic        halt_req;
  logic        count_input_pin;
  logic [15:0] tbb_a_data;
  logic        tbb_a_en;
  logic [15:0] tbb_b_data;
  logic        tbb_b_en;
  logic        irq_req;
  logic [2:0]  irq_level;
  logic [3:0]  irq_arb_id;
  logic [15:0] seen_a;
  logic [15:0] seen_b;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          comparisons;

  frcu_top #(.ADDR_W(12)) frcu_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .prescaled_tick(prescaled_tick),
    .prescaler_run(prescaler_run), .halt_req(halt_req), .arb_id_field(3'h5),
    .count_input_pin(count_input_pin), .tbb_a_data(tbb_a_data), .tbb_a_en(tbb_a_en),
    .tbb_b_data(tbb_b_data), .tbb_b_en(tbb_b_en), .irq_req(irq_req),
    .irq_level(irq_level), .irq_arb_id(irq_arb_id));
  frcu_tbb_model frcu_tbb_model_i (.pclk(pclk), .tbb_a_data(tbb_a_data),
    .tbb_a_en(tbb_a_en), .tbb_b_data(tbb_b_data), .tbb_b_en(tbb_b_en),
    .seen_a(seen_a), .seen_b(seen_b));

  always #2.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Request is held until the edge that samples pready high, then released.
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input string n, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(n, {16'h0000, e}, rd);
  endtask

  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge pclk);
      prescaled_tick <= 6'(1 << k);
      @(posedge pclk);
      prescaled_tick <= 6'h00;
    end
  endtask

  // Five cycles per level keeps the pin well under a quarter of pclk.
  task automatic pin_to(input logic v);
    @(posedge pclk);
    count_input_pin <= v;
    repeat (4) @(posedge pclk);
  endtask

  function automatic logic [15:0] sc(input logic [2:0] il, input logic b, input logic [2:0] s);
    return {1'b0, il, 1'b1, 1'b0, ~b, b, 5'h00, s};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h3;
    prescaled_tick = 6'h00;
    prescaler_run = 1'b0;
    halt_req = 1'b0;
    count_input_pin = 1'b0;
    n_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(A_SC, "control reset", 16'h0000);
    rdc(A_CNT, "counter reset", 16'h0000);
    apb(1'b1, A_R2, 16'hffff);
    rdc(A_R2, "reserved 2", 16'h0000);
    rdc(A_R3, "reserved 3", 16'h0000);
    apb(1'b0, 12'h020, 16'h0000);
    chk("unmapped error", 32'h0000_0001, 32'(err));
    apb(1'b1, A_SC, 16'hfdfd);
    rdc(A_SC, "control fields", 16'h7905);
    // The selected tick pulses, so only the stopped prescaler can hold the count.
    pulse(5, 3);
    rdc(A_CNT, "held before run", 16'h0000);
    $display("test reset and map done");
    prescaler_run <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, A_SC, sc(3'h5, 1'b0, 3'(k)));
      apb(1'b1, A_CNT, 16'h0000);
      pulse(k, 3);
      pulse((k + 1) % 6, 2);
      rdc(A_CNT, "tick count", 16'h0003);
      chk("bus a", 32'h0000_0003, {16'h0000, seen_a});
    end
    halt_req <= 1'b1;
    pulse(5, 2);
    rdc(A_CNT, "halted", 16'h0003);
    rdc(A_SC, "control in halt", sc(3'h5, 1'b0, 3'h5));
    halt_req <= 1'b0;
    pulse(5, 1);
    rdc(A_CNT, "resumed", 16'h0004);
    $display("test sources and halt done");
    apb(1'b1, A_SC, sc(3'h5, 1'b1, `FRCU_SRC_PIN_RISE));
    apb(1'b1, A_CNT, 16'h0000);
    pin_to(1'b1);
    pin_to(1'b0);
    pin_to(1'b1);
    pin_to(1'b0);
    rdc(A_CNT, "rising edges", 16'h0002);
    chk("bus b", 32'h0000_0002, {16'h0000, seen_b});
    chk("bus a off", 32'h0000_0000, {15'h0000, tbb_a_en, tbb_a_data});
    pin_to(1'b1);
    rdc(A_SC, "pin level", sc(3'h5, 1'b1, 3'h7) | 16'h0080);
    apb(1'b1, A_SC, sc(3'h5, 1'b1, `FRCU_SRC_PIN_FALL));
    pin_to(1'b0);
    rdc(A_CNT, "falling edge", 16'h0004);
    $display("test pin done");
    apb(1'b1, A_SC, sc(3'h5, 1'b0, 3'h0));
    apb(1'b1, A_CNT, 16'hffff);
    pulse(0, 1);
    rdc(A_CNT, "rollover", 16'h0000);
    apb(1'b1, A_SC, sc(3'h5, 1'b0, 3'h0));
    rdc(A_SC, "flag kept", sc(3'h5, 1'b0, 3'h0) | 16'h8000);
    chk("irq", 32'h0000_0001, 32'(irq_req));
    chk("irq level", 32'h0000_0005, 32'(irq_level));
    chk("arb id", 32'h0000_000d, 32'(irq_arb_id));
    apb(1'b1, A_SC, sc(3'h5, 1'b0, 3'h0));
    rdc(A_SC, "flag cleared", sc(3'h5, 1'b0, 3'h0));
    chk("irq dropped", 32'h0000_0000, 32'(irq_req));
    apb(1'b1, A_CNT, 16'hffff);
    pulse(0, 1);
    rdc(A_SC, "flag again", sc(3'h5, 1'b0, 3'h0) | 16'h8000);
    apb(1'b1, A_CNT, 16'hffff);
    pulse(0, 1);
    apb(1'b1, A_SC, sc(3'h5, 1'b0, 3'h0));
    rdc(A_SC, "clear cancelled", sc(3'h5, 1'b0, 3'h0) | 16'h8000);
    // Writing one to the flag leaves it set, so only the level gates the request.
    apb(1'b1, A_SC, sc(3'h0, 1'b0, 3'h0) | 16'h8000);
    rdc(A_SC, "level zero", sc(3'h0, 1'b0, 3'h0) | 16'h8000);
    chk("irq disabled", 32'h0000_0000, {29'h0, irq_level} | 32'(irq_req));
    apb(1'b1, A_SC, sc(3'h5, 1'b0, 3'h0));
    apb(1'b1, A_CNT, 16'hffff);
    apb(1'b1, A_CNT, 16'h0000);
    rdc(A_SC, "load no flag", sc(3'h5, 1'b0, 3'h0));
    chk("load no irq", 32'h0000_0000, 32'(irq_req));
    $display("test overflow done");
    report_and_stop();
  end
endmodule
